/* shared/ebs_pkg.sv */
// constants, field layouts and types of the endpoint buffer select link
// shared by the device end, the controller end, the checker and the bench
package ebs_pkg;

  // clock and selector settle time
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned SETTLE_NS     = 400;
  localparam int unsigned SETTLE_CYC_I  = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETTLE_W      = 4;
  localparam logic [SETTLE_W-1:0] SETTLE_CYC = SETTLE_W'(SETTLE_CYC_I);

  // device register byte addresses
  localparam logic [7:0] ADDR_MAXP  = 8'h04;
  localparam logic [7:0] ADDR_TYPE  = 8'h08;
  localparam logic [7:0] ADDR_BLEN  = 8'h1C;
  localparam logic [7:0] ADDR_BSTAT = 8'h1E;
  localparam logic [7:0] ADDR_DATA  = 8'h20;
  localparam logic [7:0] ADDR_CTRL  = 8'h28;
  localparam logic [7:0] ADDR_SEL   = 8'h2C;

  // endpoint_selector fields
  localparam logic [7:0] SEL_RESET     = 8'h20;
  localparam logic [7:0] SEL_RSVD_MASK = 8'hD0;
  localparam int unsigned SEL_SETUP_BIT = 5;
  localparam int unsigned SEL_EP_LSB    = 1;
  localparam int unsigned SEL_DIR_BIT   = 0;

  // endpoint_buffer_control fields
  localparam logic [7:0] CTRL_RESET     = 8'h00;
  localparam logic [7:0] CTRL_RSVD_MASK = 8'hE0;
  localparam int unsigned CTRL_CLEAR      = 4;
  localparam int unsigned CTRL_VALID      = 3;
  localparam int unsigned CTRL_DATA_STAGE = 2;
  localparam int unsigned CTRL_STAT       = 1;
  localparam int unsigned CTRL_STALL      = 0;

  // buffer status and endpoint type fields
  localparam int unsigned BSTAT_FULL  = 0;
  localparam int unsigned BSTAT_STALL = 1;
  localparam int unsigned TYPE_ISO    = 0;

  // buffers: index {ep,dir}, setup buffer last
  localparam int unsigned NBUF   = 17;
  localparam int unsigned BIDX_W = 5;
  localparam logic [BIDX_W-1:0] SETUP_IDX = 5'h10;
  localparam int unsigned CNT_W  = 11;
  localparam logic [CNT_W-1:0] CNT_STEP = 11'h002;

  // controller registers on axi4-lite
  localparam logic [7:0] HC_CMD    = 8'h00;
  localparam logic [7:0] HC_STATUS = 8'h04;
  localparam logic [7:0] HC_DMA_EP = 8'h08;
  localparam int unsigned CMD_ADDR_LSB = 0;
  localparam int unsigned CMD_WR_BIT   = 8;
  localparam int unsigned CMD_DBL_BIT  = 9;
  localparam int unsigned CMD_DATA_LSB = 16;
  localparam int unsigned ST_BUSY_BIT  = 0;
  localparam int unsigned ST_ERR_BIT   = 1;
  localparam int unsigned ST_RD_LSB    = 16;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {TOK_OUT, TOK_IN, TOK_SETUP} ebs_tok_t;
  typedef enum logic [1:0] {HS_ACK, HS_NAK, HS_STALL, HS_DATA} ebs_hs_t;

  // selector to buffer index
  function automatic logic [BIDX_W-1:0] ebs_buf_index(input logic [7:0] sel);
    if (sel[SEL_SETUP_BIT]) return SETUP_IDX;
    return {1'b0, sel[SEL_EP_LSB +: 3], sel[SEL_DIR_BIT]};
  endfunction

  function automatic logic ebs_is_tx(input logic [BIDX_W-1:0] idx);
    return (idx != SETUP_IDX) && idx[0];
  endfunction

endpackage

/* shared/ebs_if.sv */
// register bus between controller and device end
// assumes both ends run on the same aclk
`timescale 1ns/10ps
interface ebs_if;
  logic [7:0]  addr;
  logic        wr;
  logic        rd;
  logic [15:0] wdata;
  logic [15:0] rdata;

  modport dev (input addr, input wr, input rd, input wdata, output rdata);
  modport ctl (output addr, output wr, output rd, output wdata, input rdata);
endinterface

/* hw/ebs_device.sv */
// device end: endpoint selector, indexed buffer registers, token answers
// assumes the controller keeps the access rules of the register bus
// Behaviour
// - indexed registers follow the selected buffer
// - endpoint 1 receive selected by 02h
// - selector never names the dma endpoint
// - wait 400 ns after selector write
// - selector fields setup, number, direction
// - setup bit cleared for other buffers
// - direction 0 receive, 1 transmit
// - setup, control and data buffer decode
// - select endpoint before buffer control access
// - buffer control byte field layout
// - clear bit empties selected receive buffer
// - receive buffer empties when fully read
// - double buffer needs two clear pulses
// - validate marks transmit data ready
// - full packet validates automatically
// - validate only for short packets
// - reserved bits written at reset value
// - data stage enable gates control data
// - status acknowledge answers status stage
// - stall answers stall, not isochronous
`timescale 1ns/10ps
module ebs_device
  import ebs_pkg::*;
(
  input  logic             aclk,
  input  logic             aresetn,
  input  logic             usb_bus_reset,
  ebs_if.dev               bus,
  input  logic             tok_valid,
  input  ebs_tok_t         tok_kind,
  input  logic [2:0]       tok_ep,
  input  logic [CNT_W-1:0] tok_len,
  output logic             hs_valid,
  output ebs_hs_t          hs_code,
  output logic [CNT_W-1:0] hs_len
);

  typedef struct packed {
    logic [7:0]                 sel;
    logic                       data_stage_enable;
    logic                       stat_ack;
    logic [NBUF-1:0]            stall;
    logic [NBUF-1:0]            iso;
    logic [NBUF-1:0]            tx_valid;
    logic [NBUF-1:0][CNT_W-1:0] count;
    logic [NBUF-1:0][CNT_W-1:0] maxp;
    logic [15:0]                rdata;
    logic                       hs_valid;
    ebs_hs_t                    hs_code;
    logic [CNT_W-1:0]           hs_len;
  } ebs_dev_t;

  ebs_dev_t          s;
  ebs_dev_t          next_s;
  logic [BIDX_W-1:0] b;
  logic [BIDX_W-1:0] tb;

  assign bus.rdata = s.rdata;
  assign hs_valid  = s.hs_valid;
  assign hs_code   = s.hs_code;
  assign hs_len    = s.hs_len;

  always_comb begin
    next_s = s;
    next_s.hs_valid = 1'b0;
    b  = ebs_buf_index(s.sel);
    tb = (tok_kind == TOK_SETUP) ? SETUP_IDX : {1'b0, tok_ep, tok_kind == TOK_IN};

    // register writes
    if (bus.wr) begin
      case (bus.addr)
        ADDR_SEL: begin
          next_s.sel = bus.wdata[7:0];
        end
        ADDR_CTRL: begin
          if (bus.wdata[CTRL_CLEAR] && !ebs_is_tx(b)) begin
            next_s.count[b] = '0;
          end
          if (bus.wdata[CTRL_VALID] && ebs_is_tx(b)) begin
            next_s.tx_valid[b] = 1'b1;
          end
          next_s.data_stage_enable = bus.wdata[CTRL_DATA_STAGE];
          next_s.stat_ack          = bus.wdata[CTRL_STAT];
          next_s.stall[b]          = bus.wdata[CTRL_STALL];
        end
        ADDR_DATA: begin
          if (ebs_is_tx(b) && !s.tx_valid[b]) begin
            next_s.count[b] = s.count[b] + CNT_STEP;
            if (next_s.count[b] >= s.maxp[b]) begin
              next_s.tx_valid[b] = 1'b1;
            end
          end
        end
        ADDR_BLEN: begin
          next_s.count[b] = bus.wdata[CNT_W-1:0];
        end
        ADDR_MAXP: begin
          next_s.maxp[b] = bus.wdata[CNT_W-1:0];
        end
        ADDR_TYPE: begin
          next_s.iso[b] = bus.wdata[TYPE_ISO];
        end
        default: begin
        end
      endcase
    end

    // register reads
    if (bus.rd) begin
      next_s.rdata = '0;
      case (bus.addr)
        ADDR_SEL: begin
          next_s.rdata[7:0] = s.sel;
        end
        ADDR_CTRL: begin
          next_s.rdata[CTRL_DATA_STAGE] = s.data_stage_enable;
          next_s.rdata[CTRL_STAT]       = s.stat_ack;
          next_s.rdata[CTRL_STALL]      = s.stall[b];
        end
        ADDR_DATA: begin
          if (!ebs_is_tx(b)) begin
            next_s.count[b] = (s.count[b] > CNT_STEP) ? s.count[b] - CNT_STEP : '0;
          end
        end
        ADDR_BLEN: begin
          next_s.rdata[CNT_W-1:0] = s.count[b];
        end
        ADDR_BSTAT: begin
          next_s.rdata[BSTAT_FULL]  = ebs_is_tx(b) ? s.tx_valid[b] : (s.count[b] != '0);
          next_s.rdata[BSTAT_STALL] = s.stall[b];
        end
        ADDR_MAXP: begin
          next_s.rdata[CNT_W-1:0] = s.maxp[b];
        end
        ADDR_TYPE: begin
          next_s.rdata[TYPE_ISO] = s.iso[b];
        end
        default: begin
        end
      endcase
    end

    // tokens from the usb host
    if (tok_valid) begin
      next_s.hs_valid = 1'b1;
      next_s.hs_code  = HS_NAK;
      next_s.hs_len   = '0;
      if (tok_kind == TOK_SETUP) begin
        next_s.count[SETUP_IDX] = tok_len;
        next_s.stat_ack = 1'b0;
        next_s.data_stage_enable = 1'b0;
        next_s.hs_code  = HS_ACK;
      end else if (s.stall[tb] && !s.iso[tb]) begin
        next_s.hs_code = HS_STALL;
      end else if (tok_ep == '0 && s.stat_ack) begin
        next_s.stat_ack = 1'b0;
        next_s.hs_code  = (tok_kind == TOK_IN) ? HS_DATA : HS_ACK;
      end else if (tok_ep == '0 && !s.data_stage_enable) begin
        next_s.hs_code = HS_NAK;
      end else if (tok_kind == TOK_IN) begin
        if (s.tx_valid[tb]) begin
          next_s.hs_code      = HS_DATA;
          next_s.hs_len       = s.count[tb];
          next_s.tx_valid[tb] = 1'b0;
          next_s.count[tb]    = '0;
        end
      end else if (s.count[tb] == '0) begin
        next_s.count[tb] = tok_len;
        next_s.hs_code   = HS_ACK;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || usb_bus_reset) begin
      s                   <= '0;
      s.sel               <= SEL_RESET;
      s.hs_code           <= HS_ACK;
      s.data_stage_enable <= CTRL_RESET[CTRL_DATA_STAGE];
      s.stat_ack          <= CTRL_RESET[CTRL_STAT];
    end else begin
      s <= next_s;
    end
  end

endmodule

/* hw/ebs_host.sv */
// controller end: takes commands over axi4-lite, drives the device register bus
// assumes the device answers reads one cycle after the read strobe
`timescale 1ns/10ps
module ebs_host
  import ebs_pkg::*;
(
  input  logic        aclk,
  input  logic        aresetn,
  input  logic [7:0]  s_axi_awaddr,
  input  logic        s_axi_awvalid,
  output logic        s_axi_awready,
  input  logic [31:0] s_axi_wdata,
  input  logic [3:0]  s_axi_wstrb,
  input  logic        s_axi_wvalid,
  output logic        s_axi_wready,
  output logic [1:0]  s_axi_bresp,
  output logic        s_axi_bvalid,
  input  logic        s_axi_bready,
  input  logic [7:0]  s_axi_araddr,
  input  logic        s_axi_arvalid,
  output logic        s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0]  s_axi_rresp,
  output logic        s_axi_rvalid,
  input  logic        s_axi_rready,
  ebs_if.ctl          bus
);

  typedef enum logic [1:0] {H_IDLE, H_ISSUE, H_CAPT, H_SETTLE} ebs_hst_t;

  typedef struct packed {
    ebs_hst_t            st;
    logic                awready;
    logic                wready;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                arready;
    logic                rvalid;
    logic [1:0]          rresp;
    logic [31:0]         rdata;
    logic                aw_held;
    logic                w_held;
    logic [7:0]          awaddr;
    logic [31:0]         wdata;
    logic [3:0]          wstrb;
    logic [2:0]          dma_ep;
    logic                sel_done;
    logic                err;
    logic [15:0]         rd_value;
    logic [1:0]          toggles;
    logic [SETTLE_W-1:0] settle;
    logic [7:0]          addr;
    logic                wr;
    logic                rd;
    logic [15:0]         bwdata;
  } ebs_host_t;

  ebs_host_t   s;
  ebs_host_t   next_s;
  logic [7:0]  a;
  logic [15:0] d;
  logic        bad;
  logic        is_wr;

  assign s_axi_awready = s.awready;
  assign s_axi_wready  = s.wready;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid  = s.rvalid;
  assign s_axi_rresp   = s.rresp;
  assign s_axi_rdata   = s.rdata;
  assign bus.addr      = s.addr;
  assign bus.wr        = s.wr;
  assign bus.rd        = s.rd;
  assign bus.wdata     = s.bwdata;

  always_comb begin
    next_s = s;
    a      = s.wdata[CMD_ADDR_LSB +: 8];
    d      = s.wdata[CMD_DATA_LSB +: 16];
    is_wr  = s.wdata[CMD_WR_BIT];
    bad    = 1'b0;

    // axi write channels, taken in either order
    if (s_axi_awvalid && s.awready) begin
      next_s.aw_held = 1'b1;
      next_s.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready) begin
      next_s.w_held = 1'b1;
      next_s.wdata  = s_axi_wdata;
      next_s.wstrb  = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end

    // device access sequencer
    case (s.st)
      H_ISSUE: begin
        if (s.toggles != '0) begin
          next_s.bwdata[CTRL_CLEAR] = !s.bwdata[CTRL_CLEAR];
          next_s.toggles = s.toggles - 2'h1;
        end else begin
          next_s.wr = 1'b0;
          next_s.rd = 1'b0;
          if (s.rd) begin
            next_s.st = H_CAPT;
          end else if (s.addr == ADDR_SEL) begin
            next_s.st     = H_SETTLE;
            next_s.settle = SETTLE_CYC;
          end else begin
            next_s.st = H_IDLE;
          end
        end
      end
      H_CAPT: begin
        next_s.rd_value = bus.rdata;
        next_s.st       = H_IDLE;
      end
      H_SETTLE: begin
        next_s.settle = s.settle - 4'h1;
        if (s.settle == 4'h1) begin
          next_s.st = H_IDLE;
        end
      end
      default: begin
      end
    endcase

    // register write decode
    if (s.aw_held && s.w_held && !s.bvalid) begin
      next_s.aw_held = 1'b0;
      next_s.w_held  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = RESP_OKAY;
      case (s.awaddr)
        HC_CMD: begin
          if (s.st != H_IDLE) begin
            next_s.err = 1'b1;
          end else begin
            if (a == ADDR_SEL) begin
              d[15:8] = '0;
              d[7:0]  = (d[7:0] & ~SEL_RSVD_MASK) | (SEL_RESET & SEL_RSVD_MASK);
              if (d[SEL_EP_LSB +: 3] != '0 || d[SEL_DIR_BIT]) begin
                d[SEL_SETUP_BIT] = 1'b0;
              end
              bad = is_wr && (d[SEL_EP_LSB +: 3] == s.dma_ep);
            end
            if (a == ADDR_CTRL) begin
              d[15:8] = '0;
              d[7:0]  = d[7:0] & ~CTRL_RSVD_MASK;
              bad     = !s.sel_done;
            end
            next_s.err = bad;
            if (!bad) begin
              next_s.st      = H_ISSUE;
              next_s.addr    = a;
              next_s.wr      = is_wr;
              next_s.rd      = !is_wr;
              next_s.bwdata  = d;
              next_s.toggles = '0;
              if (is_wr && a == ADDR_SEL) begin
                next_s.sel_done = 1'b1;
              end
              if (is_wr && a == ADDR_CTRL && d[CTRL_CLEAR]) begin
                next_s.toggles = s.wdata[CMD_DBL_BIT] ? 2'h3 : 2'h1;
              end
            end
          end
        end
        HC_DMA_EP: begin
          if (s.wstrb[0]) begin
            next_s.dma_ep = s.wdata[2:0];
          end
        end
        default: begin
          next_s.bresp = RESP_SLVERR;
        end
      endcase
    end

    // axi read channel
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = RESP_OKAY;
      next_s.rdata  = '0;
      case (s_axi_araddr)
        HC_CMD: begin
        end
        HC_STATUS: begin
          next_s.rdata[ST_BUSY_BIT]        = (s.st != H_IDLE);
          next_s.rdata[ST_ERR_BIT]         = s.err;
          next_s.rdata[ST_RD_LSB +: 16]    = s.rd_value;
        end
        HC_DMA_EP: begin
          next_s.rdata[2:0] = s.dma_ep;
        end
        default: begin
          next_s.rresp = RESP_SLVERR;
        end
      endcase
    end

    next_s.awready = !next_s.aw_held && !next_s.bvalid;
    next_s.wready  = !next_s.w_held && !next_s.bvalid;
    next_s.arready = !next_s.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule

/* testbench/ebs_assertions.sv */
// checker on the device register bus between controller end and device end
// assumes one clock aclk and a synchronous active-low reset aresetn
`timescale 1ns/10ps
module ebs_assertions
  import ebs_pkg::*;
(
  input logic        aclk,
  input logic        aresetn,
  input logic [7:0]  addr,
  input logic        wr,
  input logic        rd,
  input logic [15:0] wdata,
  input logic [15:0] rdata
);
  logic sel_wr;
  logic ctl_wr;
  logic sel_seen;

  assign sel_wr = wr && (addr == ADDR_SEL);
  assign ctl_wr = wr && (addr == ADDR_CTRL);

  // any selector write since reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_seen <= 1'b0;
    end else if (sel_wr) begin
      sel_seen <= 1'b1;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_settle_quiet: assert property (
    sel_wr |=> (!(wr || rd)) [*5] ##1 (!(wr || rd)) [*5])
    else $error("access inside settle time");
  a_sel_reserved: assert property (
    sel_wr |-> (wdata[7:0] & SEL_RSVD_MASK) == 8'h00)
    else $error("selector reserved bits set");
  a_ctrl_reserved: assert property (
    ctl_wr |-> (wdata[7:0] & CTRL_RSVD_MASK) == 8'h00)
    else $error("control reserved bits set");
  a_setup_ep_zero: assert property (
    sel_wr && wdata[SEL_SETUP_BIT] |-> wdata[3:0] == 4'h0)
    else $error("setup bit with other buffer");
  a_ctrl_after_select: assert property (
    (wr || rd) && addr == ADDR_CTRL |-> sel_seen)
    else $error("control access before select");
  a_clear_released: assert property (
    ctl_wr && wdata[CTRL_CLEAR] |=> ctl_wr && !wdata[CTRL_CLEAR])
    else $error("clear bit not released");
  a_read_pulse: assert property (
    rd |=> !rd)
    else $error("read strobe too long");
  a_strobe_single: assert property (
    !(wr && rd))
    else $error("read and write together");

  c_sel_write: cover property (sel_wr);
  c_double_clear: cover property (ctl_wr && wdata[CTRL_CLEAR] ##2 ctl_wr && wdata[CTRL_CLEAR]);
  c_read_data: cover property (rd ##1 rdata != 16'h0000);
endmodule

/* testbench/usb_endpoint_buffer_select_test.sv */
// bench: axi4-lite commands to the controller end, tokens to the device end
// assumes both ends meet through ebs_if on one aclk
`timescale 1ns/10ps
module usb_endpoint_buffer_select_test
  import ebs_pkg::*;
;
  logic             aclk, aresetn, usb_bus_reset;
  logic [7:0]       awaddr, araddr;
  logic [31:0]      wdata, rdata, st, v;
  logic             awvalid, awready, wvalid, wready, bvalid, bready;
  logic             arvalid, arready, rvalid, rready, tok_valid, hs_valid;
  logic [1:0]       bresp, rresp;
  ebs_tok_t         tok_kind;
  ebs_hs_t          hs_code;
  logic [2:0]       tok_ep;
  logic [CNT_W-1:0] tok_len, hs_len;
  int               mismatches, checks;

  ebs_if link();
  ebs_device i_ebs_device (.aclk(aclk), .aresetn(aresetn), .usb_bus_reset(usb_bus_reset),
    .bus(link.dev), .tok_valid(tok_valid), .tok_kind(tok_kind), .tok_ep(tok_ep),
    .tok_len(tok_len), .hs_valid(hs_valid), .hs_code(hs_code), .hs_len(hs_len));
  ebs_host i_ebs_host (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .bus(link.ctl));
  ebs_assertions i_ebs_assertions (.aclk(aclk), .aresetn(aresetn), .addr(link.addr),
    .wr(link.wr), .rd(link.rd), .wdata(link.wdata), .rdata(link.rdata));

  task automatic stop_test();
    if (mismatches == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t: got %h want %h", $time, g, e);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    chk(16'(bresp), 16'(er));
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    chk(16'(rresp), 16'(er));
    rready <= 1'b0;
  endtask

  task automatic dev_cmd(input logic [7:0] a, input logic w, input logic dbl,
                         input logic [15:0] d);
    axi_wr(HC_CMD, {d, 6'h00, dbl, w, a}, RESP_OKAY);
    do axi_rd(HC_STATUS, RESP_OKAY, st); while (st[ST_BUSY_BIT] !== 1'b0);
  endtask

  task automatic dwr(input logic [7:0] a, input logic [15:0] d);
    dev_cmd(a, 1'b1, 1'b0, d);
  endtask

  task automatic dchk(input logic [7:0] a, input logic [15:0] e,
                      input logic [15:0] m = 16'hFFFF);
    dev_cmd(a, 1'b0, 1'b0, 16'h0000);
    chk(st[31:16] & m, e);
  endtask

  task automatic tok(input ebs_tok_t k, input logic [2:0] ep, input logic [CNT_W-1:0] n,
                     input ebs_hs_t eh, input logic [CNT_W-1:0] el);
    @(posedge aclk);
    tok_valid <= 1'b1;
    tok_kind  <= k;
    tok_ep    <= ep;
    tok_len   <= n;
    @(posedge aclk);
    tok_valid <= 1'b0;
    @(posedge aclk);
    chk(16'(hs_valid), 16'h0001);
    chk(16'(hs_code), 16'(eh));
    if (eh == HS_DATA) begin
      chk(16'(hs_len), 16'(el));
    end
    @(posedge aclk);
    chk(16'(hs_valid), 16'h0000);
  endtask

  initial begin
    aclk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) aclk = ~aclk;
  end

  initial begin
    #(30000 * CLK_PERIOD_NS);
    mismatches++;
    stop_test();
  end

  initial begin
    {aresetn, usb_bus_reset, awvalid, wvalid, bready, arvalid, rready, tok_valid} = '0;
    {awaddr, araddr, wdata, tok_ep, tok_len} = '0;
    tok_kind = TOK_OUT;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    // controller registers, unmapped place
    axi_wr(8'h40, 32'h0000_0000, RESP_SLVERR);
    axi_rd(8'h40, RESP_SLVERR, v);
    chk(v[15:0], 16'h0000);
    axi_wr(HC_DMA_EP, 32'h0000_0007, RESP_OKAY);
    axi_rd(HC_DMA_EP, RESP_OKAY, v);
    chk(v[15:0], 16'h0007);
    dchk(ADDR_SEL, 16'h0020);
    dev_cmd(ADDR_CTRL, 1'b0, 1'b0, 16'h0000);
    chk(16'(st[ST_ERR_BIT]), 16'h0001);
    // selector fields, reserved and setup handling
    for (int i = 0; i < 14; i++) begin
      dwr(ADDR_SEL, 16'(i));
      dchk(ADDR_SEL, 16'(i));
    end
    dwr(ADDR_SEL, 16'h00D2);
    dchk(ADDR_SEL, 16'h0002);
    dwr(ADDR_SEL, 16'h0022);
    dchk(ADDR_SEL, 16'h0002);
    dwr(ADDR_SEL, 16'h0020);
    dev_cmd(ADDR_SEL, 1'b1, 1'b0, 16'h000E);
    chk(16'(st[ST_ERR_BIT]), 16'h0001);
    dchk(ADDR_SEL, 16'h0020);
    // indexed registers follow the selection
    dwr(ADDR_SEL, 16'h0003);
    dwr(ADDR_MAXP, 16'h0008);
    dwr(ADDR_SEL, 16'h0002);
    dwr(ADDR_MAXP, 16'h0010);
    dwr(ADDR_SEL, 16'h0003);
    dchk(ADDR_MAXP, 16'h0008);
    dwr(ADDR_SEL, 16'h0002);
    dchk(ADDR_MAXP, 16'h0010);
    // transmit: short packet validated by hand, full one by itself
    dwr(ADDR_SEL, 16'h0003);
    dwr(ADDR_DATA, 16'hA5A5);
    dwr(ADDR_DATA, 16'h5A5A);
    tok(TOK_IN, 3'h1, 11'h000, HS_NAK, 11'h000);
    dwr(ADDR_CTRL, 16'h0008);
    tok(TOK_IN, 3'h1, 11'h000, HS_DATA, 11'h004);
    repeat (4) dwr(ADDR_DATA, 16'h1234);
    dchk(ADDR_BSTAT, 16'h0001, 16'h0001);
    tok(TOK_IN, 3'h1, 11'h000, HS_DATA, 11'h008);
    // receive: emptied by reading, forced clear single and double
    tok(TOK_OUT, 3'h2, 11'h004, HS_ACK, 11'h000);
    tok(TOK_OUT, 3'h2, 11'h004, HS_NAK, 11'h000);
    dwr(ADDR_SEL, 16'h0004);
    dchk(ADDR_DATA, 16'h0000, 16'h0000);
    dchk(ADDR_DATA, 16'h0000, 16'h0000);
    tok(TOK_OUT, 3'h2, 11'h004, HS_ACK, 11'h000);
    dchk(ADDR_BLEN, 16'h0004);
    dchk(ADDR_BSTAT, 16'h0001, 16'h0001);
    dwr(ADDR_BLEN, 16'h0006);
    dchk(ADDR_BLEN, 16'h0006);
    dwr(ADDR_CTRL, 16'h0010);
    dchk(ADDR_BLEN, 16'h0000);
    tok(TOK_OUT, 3'h2, 11'h004, HS_ACK, 11'h000);
    dev_cmd(ADDR_CTRL, 1'b1, 1'b1, 16'h0010);
    tok(TOK_OUT, 3'h2, 11'h004, HS_ACK, 11'h000);
    tok(TOK_OUT, 3'h2, 11'h004, HS_NAK, 11'h000);
    // stall, and no stall on isochronous
    dwr(ADDR_SEL, 16'h0002);
    dwr(ADDR_CTRL, 16'h0001);
    dchk(ADDR_CTRL, 16'h0001);
    dchk(ADDR_BSTAT, 16'h0002, 16'h0002);
    tok(TOK_OUT, 3'h1, 11'h002, HS_STALL, 11'h000);
    dwr(ADDR_TYPE, 16'h0001);
    dchk(ADDR_TYPE, 16'h0001);
    tok(TOK_OUT, 3'h1, 11'h002, HS_ACK, 11'h000);
    // control transfer: data stage and status stage
    tok(TOK_SETUP, 3'h0, 11'h008, HS_ACK, 11'h000);
    tok(TOK_OUT, 3'h0, 11'h002, HS_NAK, 11'h000);
    dwr(ADDR_SEL, 16'h0000);
    dwr(ADDR_CTRL, 16'h0004);
    tok(TOK_IN, 3'h0, 11'h000, HS_NAK, 11'h000);
    tok(TOK_OUT, 3'h0, 11'h002, HS_ACK, 11'h000);
    dwr(ADDR_CTRL, 16'h0006);
    tok(TOK_IN, 3'h0, 11'h000, HS_DATA, 11'h000);
    tok(TOK_IN, 3'h0, 11'h000, HS_NAK, 11'h000);
    dwr(ADDR_CTRL, 16'h0006);
    tok(TOK_OUT, 3'h0, 11'h000, HS_ACK, 11'h000);
    tok(TOK_OUT, 3'h0, 11'h000, HS_NAK, 11'h000);
    // usb bus reset restores selector and control
    dwr(ADDR_SEL, 16'h0003);
    dwr(ADDR_CTRL, 16'h0001);
    @(posedge aclk);
    usb_bus_reset <= 1'b1;
    @(posedge aclk);
    usb_bus_reset <= 1'b0;
    dchk(ADDR_SEL, 16'h0020);
    dwr(ADDR_SEL, 16'h0003);
    dchk(ADDR_CTRL, 16'h0000);
    stop_test();
  end
endmodule
